// File: design/gpio_port.sv
// Six-pin general purpose port with edge detection
module gpio_port (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Power-on reset and I/O supply indication
    input wire logic por_active_in,
    input wire logic vio_valid_in,
    // Register access from the serial interface
    input wire gpio_port_pkg::reg_req_t req_in,
    output logic [7:0] rdata_out,
    output logic rdata_valid_out,
    // Pins: input level, drive level, output enable, alternate routing
    input wire logic [gpio_port_pkg::PIN_CNT-1:0] pin_in,
    output gpio_port_pkg::pin_drive_t pin_out,
    // Sticky edge status for the interrupt logic elsewhere
    output logic edge_pending_out
);
    import gpio_port_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Internal reset

    logic rst_int;

    // Port logic stays in reset while the supply is not good
    assign rst_int = srst_in | por_active_in | ~vio_valid_in;

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisation

    logic [PIN_CNT-1:0] lvl_sync;

    // Edges are only judged on clean levels
    pin_sync u_sync (
        .clk_in(clk_in),
        .srst_in(rst_int),
        .raw_in(pin_in),
        .sync_out(lvl_sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Write decode

    logic wr_set;
    logic wr_clr;
    logic wr_dir;
    logic wr_stat;
    logic wr_rise;
    logic wr_fall;
    logic wr_func;
    logic [PIN_CNT-1:0] wbits;

    // Monitor offset has no write target
    always_comb begin
        wr_set = req_in.wr && req_in.addr == OFS_SET;
        wr_clr = req_in.wr && req_in.addr == OFS_CLR;
        wr_dir = req_in.wr && req_in.addr == OFS_DIR;
        wr_stat = req_in.wr && req_in.addr == OFS_STAT;
        wr_rise = req_in.wr && req_in.addr == OFS_RISE;
        wr_fall = req_in.wr && req_in.addr == OFS_FALL;
        wr_func = req_in.wr && req_in.addr == OFS_FUNC;
        wbits = pin_field(req_in.data);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and output level registers

    logic [PIN_CNT-1:0] out_r;
    logic [PIN_CNT-1:0] out_nxt;
    logic [PIN_CNT-1:0] dir_r;
    logic [PIN_CNT-1:0] dir_nxt;
    logic [PIN_CNT-1:0] rise_en_r;
    logic [PIN_CNT-1:0] rise_en_nxt;
    logic [PIN_CNT-1:0] fall_en_r;
    logic [PIN_CNT-1:0] fall_en_nxt;
    logic [PIN_CNT-1:0] func_r;
    logic [PIN_CNT-1:0] func_nxt;

    // Set and clear are separate offsets, so never in the same cycle
    always_comb begin
        out_nxt = out_r;
        dir_nxt = dir_r;
        rise_en_nxt = rise_en_r;
        fall_en_nxt = fall_en_r;
        func_nxt = func_r;
        if (rst_int) begin
            out_nxt = pin_field(RST_OUT);
            dir_nxt = pin_field(RST_DIR);
            rise_en_nxt = pin_field(RST_RISE);
            fall_en_nxt = pin_field(RST_FALL);
            func_nxt = pin_field(RST_FUNC);
        end else begin
            if (wr_set) begin
                out_nxt = out_r | wbits;
            end
            if (wr_clr) begin
                out_nxt = out_r & ~wbits;
            end
            if (wr_dir) begin
                dir_nxt = wbits;
            end
            if (wr_rise) begin
                rise_en_nxt = wbits;
            end
            if (wr_fall) begin
                fall_en_nxt = wbits;
            end
            if (wr_func) begin
                func_nxt = wbits;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        out_r <= out_nxt;
        dir_r <= dir_nxt;
        rise_en_r <= rise_en_nxt;
        fall_en_r <= fall_en_nxt;
        func_r <= func_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection and sticky status

    logic [PIN_CNT-1:0] prev_r;
    logic [PIN_CNT-1:0] prev_nxt;
    logic [PIN_CNT-1:0] stat_r;
    logic [PIN_CNT-1:0] stat_nxt;
    logic [PIN_CNT-1:0] rise_evt;
    logic [PIN_CNT-1:0] fall_evt;
    logic [1:0] settle_r;
    logic [1:0] settle_nxt;
    logic edge_armed;

    // A new edge beats a same-cycle clear so no event is lost.
    // The synchroniser restarts at zero, so a high pin would look like a rise
    // after reset; edges stay masked until the old level has flushed through.
    // Limitation: a real transition inside that short window is not recorded.
    always_comb begin
        settle_nxt = settle_r;
        if (rst_int) begin
            settle_nxt = 2'(SYNC_STAGES + 1);
        end else if (settle_r != 2'h0) begin
            settle_nxt = settle_r - 2'h1;
        end
        edge_armed = settle_r == 2'h0;
        rise_evt = {PIN_CNT{edge_armed}} & rise_en_r & lvl_sync & ~prev_r;
        fall_evt = {PIN_CNT{edge_armed}} & fall_en_r & ~lvl_sync & prev_r;
        prev_nxt = rst_int ? '0 : lvl_sync;
        stat_nxt = stat_r;
        if (rst_int) begin
            stat_nxt = pin_field(RST_STAT);
        end else begin
            if (wr_stat) begin
                stat_nxt = stat_r & ~wbits;
            end
            stat_nxt = stat_nxt | rise_evt | fall_evt;
        end
    end

    always_ff @(posedge clk_in) begin
        prev_r <= prev_nxt;
        stat_r <= stat_nxt;
        settle_r <= settle_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic rvalid_r;
    logic rvalid_nxt;

    // Strobe offsets read zero; reserved bits always zero
    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = 1'b0;
        if (rst_int) begin
            rdata_nxt = RD_UNMAPPED;
        end else if (req_in.rd) begin
            rvalid_nxt = 1'b1;
            case (req_in.addr)
                OFS_MON: rdata_nxt = pin_byte(lvl_sync);
                OFS_DIR: rdata_nxt = pin_byte(dir_r);
                OFS_STAT: rdata_nxt = pin_byte(stat_r);
                OFS_RISE: rdata_nxt = pin_byte(rise_en_r);
                OFS_FALL: rdata_nxt = pin_byte(fall_en_r);
                OFS_FUNC: rdata_nxt = pin_byte(func_r);
                default: rdata_nxt = RD_UNMAPPED;
            endcase
        end
    end

    always_ff @(posedge clk_in) begin
        rdata_r <= rdata_nxt;
        rvalid_r <= rvalid_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    // Drive only when GPIO-routed and configured as output
    always_comb begin
        pin_out.level = out_r;
        pin_out.oe = dir_r & func_r;
        pin_out.alt_sel = ~func_r;
    end

    assign rdata_out = rdata_r;
    assign rdata_valid_out = rvalid_r;
    assign edge_pending_out = |stat_r;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clk_in);
    endclocking

    default disable iff (rst_int);

    sequence wr_to(logic [7:0] a);
        req_in.wr && req_in.addr == a;
    endsequence

    sequence rd_to(logic [7:0] a);
        req_in.rd && req_in.addr == a;
    endsequence

    sequence pin0_low_high;
        !lvl_sync[0] ##1 lvl_sync[0];
    endsequence

    sequence pin0_high_low;
        lvl_sync[0] ##1 !lvl_sync[0];
    endsequence

    dir_reset_a: assert property (
        $fell(rst_int) |-> dir_r == '0 ##0 !wr_dir [*1] ##1 dir_r == '0)
        else $error("direction not zero after reset");

    func_reset_a: assert property (
        $fell(rst_int) |-> func_r == 6'b000011)
        else $error("function select wrong after reset");

    inputs_after_reset_a: assert property (
        $fell(rst_int) |-> pin_out.oe == '0)
        else $error("pin driven right after reset");

    set_pin_a: assert property (
        wr_to(OFS_SET) |=> out_r == ($past(out_r) | pin_field($past(req_in.data))))
        else $error("set strobe wrong");

    clr_pin_a: assert property (
        wr_to(OFS_CLR) |=> out_r == ($past(out_r) & ~pin_field($past(req_in.data))))
        else $error("clear strobe wrong");

    monitor_read_a: assert property (
        rd_to(OFS_MON) ##1 1'b1 |-> rdata_valid_out && rdata_out == pin_byte($past(lvl_sync)))
        else $error("monitor read wrong");

    monitor_nowrite_a: assert property (
        wr_to(OFS_MON) |=> $stable(out_r) && $stable(dir_r) && $stable(func_r))
        else $error("monitor write changed state");

    sync_delay_a: assert property (
        !$past(rst_int, 2) && !$past(rst_int) |-> lvl_sync == $past(pin_in, 2))
        else $error("pin sync latency not two");

    rise_detect_a: assert property (
        pin0_low_high ##0 (rise_en_r[0] && edge_armed) |=> stat_r[0])
        else $error("rising edge not recorded");

    fall_detect_a: assert property (
        pin0_high_low ##0 (fall_en_r[0] && edge_armed) |=> stat_r[0])
        else $error("falling edge not recorded");

    edge_set_a: assert property (
        (rise_evt | fall_evt) != '0
        |=> (stat_r & $past(rise_evt | fall_evt)) == $past(rise_evt | fall_evt))
        else $error("status lost an edge");

    stat_sticky_a: assert property (
        !wr_stat |=> (stat_r & $past(stat_r)) == $past(stat_r))
        else $error("status bit dropped without a clear");

    dir_write_a: assert property (
        wr_to(OFS_DIR)
        |=> dir_r == pin_field($past(req_in.data)) && pin_out.oe == (dir_r & func_r))
        else $error("direction write not applied");

    dir_readback_a: assert property (
        rd_to(OFS_DIR) |=> rdata_valid_out && rdata_out == pin_byte($past(dir_r)))
        else $error("direction read wrong");

    func_write_a: assert property (
        wr_to(OFS_FUNC) |=> pin_out.alt_sel == ~pin_field($past(req_in.data)))
        else $error("function select write not applied");

    stat_clear_a: assert property (
        wr_to(OFS_STAT) && (rise_evt | fall_evt) == '0
        |=> (stat_r & pin_field($past(req_in.data))) == '0)
        else $error("status write-one did not clear");

    reserved_zero_a: assert property (
        rdata_valid_out |-> rdata_out[1:0] == 2'b00)
        else $error("reserved bits not zero");

    supply_hold_a: assert property (
        @(posedge clk_in) disable iff (srst_in)
        !vio_valid_in |=> dir_r == '0 && stat_r == '0 && !rdata_valid_out)
        else $error("port left reset without supply");

endmodule // gpio_port

// File: design/gpio_port_pkg.sv
// Constants and types shared by the six-pin expander port
//
// Contract
// - Six pins on bits 7..2, bits 1..0 reserved
// - Set-pin write of one drives pin high
// - Clear-pin write of one drives pin low
// - Monitor reads pin levels, writes ignored
// - Direction bit one is output, resets zero
// - Status bit sets on enabled edge
// - Rising enable detects low-to-high transitions
// - Falling enable detects high-to-low transitions
// - Function select one is GPIO, resets 0x0f
// - All pins are inputs after reset
// - Held in reset until supply valid
package gpio_port_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Pin field layout
    localparam int PIN_CNT = 6;
    localparam int PIN_LSB = 2;
    localparam int PIN_MSB = 7;
    localparam int REG_W = 8;
    localparam int SYNC_STAGES = 2;

    ////////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_SET = 8'h10;
    localparam logic [7:0] OFS_CLR = 8'h11;
    localparam logic [7:0] OFS_MON = 8'h12;
    localparam logic [7:0] OFS_DIR = 8'h13;
    localparam logic [7:0] OFS_STAT = 8'h14;
    localparam logic [7:0] OFS_RISE = 8'h15;
    localparam logic [7:0] OFS_FALL = 8'h16;
    localparam logic [7:0] OFS_FUNC = 8'h17;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values, full byte as printed
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_STAT = 8'h00;
    localparam logic [7:0] RST_RISE = 8'h00;
    localparam logic [7:0] RST_FALL = 8'h00;
    localparam logic [7:0] RST_FUNC = 8'h0f;
    localparam logic [7:0] RST_OUT = 8'h00;
    localparam logic [7:0] RD_UNMAPPED = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Register access request from the serial interface
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_req_t;

    // Pin-side drive bundle
    typedef struct packed {
        logic [PIN_CNT-1:0] level;
        logic [PIN_CNT-1:0] oe;
        logic [PIN_CNT-1:0] alt_sel;
    } pin_drive_t;

    // Byte lanes 7..2 to pin vector
    function automatic logic [PIN_CNT-1:0] pin_field(input logic [7:0] b);
        return b[PIN_MSB:PIN_LSB];
    endfunction

    // Pin vector to byte, reserved bits zero
    function automatic logic [7:0] pin_byte(input logic [PIN_CNT-1:0] p);
        return {p, 2'b00};
    endfunction

endpackage

// File: design/pin_sync.sv
// Two-stage synchroniser bank for the port pins
module pin_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // Raw and synchronised levels
    input wire logic [gpio_port_pkg::PIN_CNT-1:0] raw_in,
    output logic [gpio_port_pkg::PIN_CNT-1:0] sync_out
);
    import gpio_port_pkg::*;

    logic [PIN_CNT-1:0] meta_r;
    logic [PIN_CNT-1:0] meta_nxt;
    logic [PIN_CNT-1:0] sync_r;
    logic [PIN_CNT-1:0] sync_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // One flop pair per pin; first stage feeds only the second
    for (genvar i = 0; i < PIN_CNT; i++) begin : g_bit
        always_comb begin
            meta_nxt[i] = srst_in ? 1'b0 : raw_in[i];
            sync_nxt[i] = srst_in ? 1'b0 : meta_r[i];
        end
    end

    always_ff @(posedge clk_in) begin
        meta_r <= meta_nxt;
        sync_r <= sync_nxt;
    end

    assign sync_out = sync_r;

endmodule // pin_sync

// File: verif/host_agent.sv
// Host-side register master model driving the port's request bundle
module host_agent (
    // Clock
    input wire logic clk_in,
    // Read answer
    input wire logic [7:0] rdata_in,
    input wire logic rdata_valid_in,
    // Request
    output gpio_port_pkg::reg_req_t req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_port_pkg::*;

    initial req_out = '0;

    ////////////////////////////////////////////////////////////////////////////
    // One write after an idle gap; the lines are scrambled once it is taken
    task automatic write(input logic [7:0] a, input logic [7:0] d, input int gap);
        repeat (gap) @(posedge clk_in);
        @(posedge clk_in);
        req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, data: d};
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    // One read; the answer is awaited a bounded number of edges
    task automatic read(input logic [7:0] a, output logic [7:0] d, output bit ok);
        ok = 1'b0;
        d = 8'hxx;
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, data: 8'h5a};
        @(posedge clk_in);
        req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: 8'ha5};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge clk_in);
            if (rdata_valid_in === 1'b1) begin
                ok = 1'b1;
                d = rdata_in;
            end
        end
    endtask
endmodule // host_agent

// File: verif/tb.sv
// Self-checking bench for the six-pin port against an integer model
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import gpio_port_pkg::*;

    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic por_active_in = 1'b0;
    logic vio_valid_in = 1'b1;
    logic [5:0] pin_in = 6'h00;
    reg_req_t req;
    logic [7:0] rdata;
    logic rdata_valid;
    pin_drive_t pin_out;
    logic edge_pending;
    int n_errors = 0;
    int n_compared = 0;
    int seed = 24;
    // Model: slot 0 output level, 2 pins, else register at 0x10 + slot
    int m[8];

    always #2 clk_in = ~clk_in;

    gpio_port gpio_port_inst (.clk_in(clk_in), .srst_in(srst_in),
        .por_active_in(por_active_in), .vio_valid_in(vio_valid_in), .req_in(req),
        .rdata_out(rdata), .rdata_valid_out(rdata_valid), .pin_in(pin_in),
        .pin_out(pin_out), .edge_pending_out(edge_pending));

    host_agent host_agent_inst (.clk_in(clk_in), .rdata_in(rdata),
        .rdata_valid_in(rdata_valid), .req_out(req));

    ////////////////////////////////////////////////////////////////////////////
    // Strobes and unmapped places read zero; reserved bits read zero
    function automatic logic [7:0] exp_rd(input int a);
        if (a < 'h12 || a > 'h17) return 8'h00;
        return 8'(m[a - 'h10] << 2);
    endfunction

    task automatic report_and_stop();
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_compared++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input int a);
        logic [7:0] d;
        bit ok;
        host_agent_inst.read(8'(a), d, ok);
        if (!ok) begin
            n_errors++;
            $display("CHECK FAILED read answer expected 1 seen 0");
            report_and_stop();
        end else begin
            chk("read", exp_rd(a), d);
        end
    endtask

    // Drive side of the pins follows direction and routing; looked at one
    // edge on, since a write taken at this edge only lands after it
    task automatic chk_pins();
        @(posedge clk_in);
        chk("level", 8'(m[0]), 8'(pin_out.level));
        chk("oe", 8'(m[3] & m[7]), 8'(pin_out.oe));
        chk("alt", 8'(~m[7] & 63), 8'(pin_out.alt_sel));
        chk("pending", 8'(m[4] != 0), 8'(edge_pending));
    endtask

    // Write with a random host gap and mirror it in the model
    task automatic wr(input int a, input int d);
        int p;
        p = (d >> 2) & 63;
        host_agent_inst.write(8'(a), 8'(d), $unsigned($random(seed)) % 3);
        case (a)
            'h10: m[0] |= p;
            'h11: m[0] &= ~p & 63;
            'h14: m[4] &= ~p & 63;
            'h13, 'h15, 'h16, 'h17: m[a - 'h10] = p;
            default: ;
        endcase
    endtask

    // Move the pins, log enabled edges, let the synchroniser settle
    task automatic drive_pins(input int v);
        @(posedge clk_in);
        pin_in <= 6'(v);
        m[4] |= (~m[2] & v & m[5]) | (m[2] & ~v & m[6]);
        m[2] = v & 63;
        repeat (4) @(posedge clk_in);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence: three rounds, each ended by a different reset source
    initial begin
        repeat (5) @(posedge clk_in);
        srst_in <= 1'b0;
        for (int r = 0; r < 3; r++) begin
            m = '{0, 0, m[2], 0, 0, 0, 0, 3};
            for (int a = 'h10; a <= 'h18; a++) rd_chk(a);
            chk_pins();
            for (int a = 'h13; a <= 'h17; a += 2) wr(a, $random(seed));
            wr('h16, $random(seed));
            for (int k = 0; k < 6; k++) begin
                wr('h10 + k % 2, $random(seed));
                chk_pins();
            end
            for (int a = 'h13; a <= 'h17; a++) rd_chk(a);
            for (int k = 0; k < 8; k++) begin
                drive_pins($random(seed));
                rd_chk('h12);
                rd_chk('h14);
                chk_pins();
            end
            wr('h12, $random(seed));
            rd_chk('h12);
            wr('h14, $random(seed));
            rd_chk('h14);
            wr('h13, 8'hff);
            chk_pins();
            @(posedge clk_in);
            if (r == 0) por_active_in <= 1'b1;
            if (r == 1) vio_valid_in <= 1'b0;
            if (r == 2) srst_in <= 1'b1;
            repeat (3) @(posedge clk_in);
            por_active_in <= 1'b0;
            vio_valid_in <= 1'b1;
            srst_in <= 1'b0;
            m = '{0, 0, m[2], 0, 0, 0, 0, 3};
            @(posedge clk_in);
            chk_pins();
            rd_chk('h13);
        end
        report_and_stop();
    end
endmodule // tb
